// >>> core/sar_adc_sequencer.sv
// Converter sequencer: control, result formatting, interlock and pin override
`default_nettype none
module sar_adc_sequencer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Status and control register write
  input wire logic conv_status_ctrl_reg_wr,
  input wire logic [4:0] channel_select_field,
  input wire logic continuous_conv_bit,
  input wire logic conv_irq_enable,
  // Clock register
  input wire logic [7:0] conv_clock_divider,
  input wire logic result_format_bit0,
  input wire logic result_format_bit1,
  // Data register reads
  input wire logic result_high_rd,
  input wire logic result_low_rd,
  // Low power
  input wire logic stop_mode,
  // Port logic
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_dir,
  input wire logic [7:0] shared_port_pins_in,
  output logic [7:0] shared_port_pins_out,
  output logic [7:0] shared_port_pins_oe,
  output logic [7:0] port_read_data,
  // Analog side
  output logic [4:0] mux_select,
  output logic analog_power_on,
  output logic [9:0] trial_code,
  input wire logic cmp_high,
  // Software view
  output logic [7:0] result_high_reg,
  output logic [7:0] result_low_reg,
  output logic conv_done_flag,
  output logic conv_irq,
  output logic conv_status_irq_en,
  output logic conv_status_cont,
  output logic conv_busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } seq_state_e;

  seq_state_e state_r;
  logic [4:0] chan_r;
  logic cont_r;
  logic ien_r;
  logic [7:0] div_cnt_r;
  logic tick;
  logic [4:0] clk_cnt_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic stop_s1_r;
  logic stop_s2_r;
  logic eng_done;
  logic [9:0] eng_result;
  logic lock_r;
  logic [1:0] fmt;
  logic powered;
  logic start_now;

  assign fmt = {result_format_bit1, result_format_bit0};
  assign powered = (chan_r != sar_pkg::CH_OFF);
  assign analog_power_on = powered;
  assign mux_select = chan_r;
  assign conv_status_irq_en = ien_r;
  assign conv_status_cont = cont_r;
  assign conv_busy = (state_r != ST_IDLE);

  // ----------------------------------------
  // Control and sequencing
  // ----------------------------------------
  // Synchronisers for pins, comparator and stop request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= shared_port_pins_in;
      pin_s2_r <= pin_s1_r;
      cmp_s1_r <= cmp_high;
      cmp_s2_r <= cmp_s1_r;
      stop_s1_r <= stop_mode;
      stop_s2_r <= stop_s1_r;
    end
  end

  // Control bits; reset leaves everything idle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_r <= sar_pkg::CH_OFF;
      cont_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (conv_status_ctrl_reg_wr) begin
      chan_r <= channel_select_field;
      cont_r <= continuous_conv_bit;
      ien_r <= conv_irq_enable;
    end
  end

  // Converter clock divider; software should aim for 1 MHz
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= sar_pkg::DIV_RESET;
    end else if (conv_status_ctrl_reg_wr || div_cnt_r >= conv_clock_divider) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  assign tick = (div_cnt_r >= conv_clock_divider) && !conv_status_ctrl_reg_wr;

  // Continuous mode restarts by itself after a stop abort; single mode waits for a write
  assign start_now = powered && !stop_s2_r && state_r == ST_IDLE &&
                     conv_status_ctrl_reg_wr == 1'b0 && cont_r;

  // Sequence: sample window, then ten decisions, padded to 16 ticks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      clk_cnt_r <= 5'h00;
    end else if (conv_status_ctrl_reg_wr) begin
      state_r <= ST_SAMPLE;
      clk_cnt_r <= 5'h00;
    end else if (stop_s2_r || !powered) begin
      state_r <= ST_IDLE;
      clk_cnt_r <= 5'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          clk_cnt_r <= 5'h00;
          // Without this a stop would silently end continuous operation for good
          if (start_now) begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            clk_cnt_r <= clk_cnt_r + 5'h01;
            if (clk_cnt_r == 5'(sar_pkg::SAMPLE_CLKS - 1)) begin
              state_r <= ST_CONVERT;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            clk_cnt_r <= clk_cnt_r + 5'h01;
          end
          if (tick && clk_cnt_r == sar_pkg::CONV_CLKS - 5'h01) begin
            state_r <= cont_r ? ST_SAMPLE : ST_IDLE;
            clk_cnt_r <= 5'h00;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  sar_engine u_engine (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .start(state_r == ST_SAMPLE && tick && clk_cnt_r == 5'(sar_pkg::SAMPLE_CLKS - 1)),
    .abort(conv_status_ctrl_reg_wr || stop_s2_r || !powered),
    .trial_code(trial_code),
    .cmp_high(cmp_s2_r),
    .result(eng_result),
    .done(eng_done)
  );

  // ----------------------------------------
  // Result formatting and interlock
  // ----------------------------------------
  // Interlock: high read arms, low read releases; nothing is stored while armed, so the low byte stays frozen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_r <= 1'b0;
    end else if (fmt == sar_pkg::FMT_TRUNC) begin
      lock_r <= 1'b0;
    end else if (result_low_rd) begin
      lock_r <= 1'b0;
    end else if (result_high_rd) begin
      lock_r <= 1'b1;
    end
  end

  // Result registers; a locked pair drops new results
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      result_high_reg <= 8'h00;
      result_low_reg <= 8'h00;
    end else if (eng_done && !(lock_r && fmt != sar_pkg::FMT_TRUNC)) begin
      case (fmt)
        sar_pkg::FMT_LEFT: begin
          result_high_reg <= eng_result[9:2];
          result_low_reg <= {eng_result[1:0], 6'h00};
        end
        sar_pkg::FMT_RIGHT: begin
          result_high_reg <= {6'h00, eng_result[9:8]};
          result_low_reg <= eng_result[7:0];
        end
        sar_pkg::FMT_SIGNED: begin
          result_high_reg <= {~eng_result[9], eng_result[8:2]};
          result_low_reg <= {eng_result[1:0], 6'h00};
        end
        default: begin
          result_high_reg <= 8'h00;
          result_low_reg <= eng_result[9:2];
        end
      endcase
    end
  end

  // Done flag or interrupt; a new completion wins over a clearing read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_done_flag <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      if (eng_done && !ien_r) begin
        conv_done_flag <= 1'b1;
      end else if (result_high_rd || result_low_rd || ien_r) begin
        conv_done_flag <= 1'b0;
      end
      if (eng_done && ien_r) begin
        conv_irq <= 1'b1;
      end else if (result_high_rd || result_low_rd || conv_status_ctrl_reg_wr) begin
        conv_irq <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin sharing
  // ----------------------------------------
  // Pin sharing: selected external channel is released from port control
  genvar gi;
  generate
    for (gi = 0; gi < sar_pkg::PORT_PINS; gi++) begin : g_pin
      logic in_use;
      assign in_use = powered && (chan_r == 5'(gi));
      assign shared_port_pins_oe[gi] = in_use ? 1'b0 : port_dir[gi];
      assign shared_port_pins_out[gi] = in_use ? 1'b0 : port_data[gi];
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          port_read_data[gi] <= 1'b0;
        end else begin
          port_read_data[gi] <= in_use ? 1'b0 : (port_dir[gi] ? port_data[gi] : pin_s2_r[gi]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  done_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    eng_done && ien_r |=> conv_irq && !conv_done_flag) else $error("irq not raised");
  done_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    eng_done && !ien_r |=> conv_done_flag) else $error("done flag not set");
  irq_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_status_ctrl_reg_wr && !eng_done |=> !conv_irq) else $error("irq not cleared");
  start_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_status_ctrl_reg_wr |=> state_r == ST_SAMPLE) else $error("write did not start");
  lock_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    lock_r && fmt != sar_pkg::FMT_TRUNC && !result_low_rd |=> $stable(result_high_reg))
    else $error("locked result changed");
  low_frozen_a: assert property (@(posedge ref_clk) disable iff (rst)
    lock_r && fmt != sar_pkg::FMT_TRUNC && !result_low_rd |=> $stable(result_low_reg))
    else $error("locked low byte changed");
  trunc_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    fmt == sar_pkg::FMT_TRUNC |=> !lock_r) else $error("interlock armed in truncated format");
  stop_abort_a: assert property (@(posedge ref_clk) disable iff (rst)
    stop_s2_r && !conv_status_ctrl_reg_wr |=> state_r == ST_IDLE) else $error("stop not aborting");
  cont_resume_a: assert property (@(posedge ref_clk) disable iff (rst)
    start_now |=> state_r == ST_SAMPLE) else $error("continuous mode did not resume");
  power_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !powered && !conv_status_ctrl_reg_wr |=> state_r == ST_IDLE) else $error("converter ran while powered off");
  pin_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    powered && chan_r <= sar_pkg::CH_EXT_MAX |=> port_read_data[chan_r[2:0]] == 1'b0 || $changed(chan_r))
    else $error("used pin read nonzero");
  pin_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
    powered && chan_r <= sar_pkg::CH_EXT_MAX |-> shared_port_pins_oe[chan_r[2:0]] == 1'b0)
    else $error("selected pin driven");
  single_end_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == ST_CONVERT && eng_done && !cont_r && !conv_status_ctrl_reg_wr |-> ##[1:300] state_r == ST_IDLE)
    else $error("single mode did not stop");
  cov_single_c: cover property (@(posedge ref_clk) eng_done && !cont_r);
  cov_cont_c: cover property (@(posedge ref_clk) eng_done && cont_r);
  cov_lock_c: cover property (@(posedge ref_clk) eng_done && lock_r);
  cov_irq_c: cover property (@(posedge ref_clk) conv_irq);
endmodule
`default_nettype wire

// >>> core/sar_engine.sv
// Successive-approximation bit decision engine, one bit per converter tick
`default_nettype none
module sar_engine (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  // Comparator side
  output logic [9:0] trial_code,
  input wire logic cmp_high,
  // Result
  output logic [9:0] result,
  output logic done
);
  logic [9:0] sar_r;
  logic [9:0] bit_r;
  logic busy_r;

  // Trial code is the running value with the bit under test set
  assign trial_code = sar_r | bit_r;

  // One decision per tick, MSB first; comparator high keeps the bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sar_r <= 10'h000;
      bit_r <= 10'h000;
      busy_r <= 1'b0;
      result <= 10'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_r <= 1'b0;
        bit_r <= 10'h000;
      end else if (start) begin
        sar_r <= 10'h000;
        bit_r <= 10'h200;
        busy_r <= 1'b1;
      end else if (busy_r && tick) begin
        if (cmp_high) begin
          sar_r <= sar_r | bit_r;
        end
        bit_r <= bit_r >> 1;
        if (bit_r[0]) begin
          busy_r <= 1'b0;
          result <= cmp_high ? (sar_r | bit_r) : sar_r;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/sar_pkg.sv
// Constants used by the converter sequencer; its bit-decision engine does not import them
package sar_pkg;
  localparam int unsigned RES_BITS = 10;
  localparam int unsigned CH_BITS = 5;
  localparam int unsigned PORT_PINS = 8;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [4:0] CH_REFH = 5'h1d;
  localparam logic [4:0] CH_REFL = 5'h1e;
  localparam logic [4:0] CH_EXT_MAX = 5'h07;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  // Result formats
  localparam logic [1:0] FMT_LEFT = 2'h0;
  localparam logic [1:0] FMT_RIGHT = 2'h1;
  localparam logic [1:0] FMT_SIGNED = 2'h2;
  localparam logic [1:0] FMT_TRUNC = 2'h3;
  // Five sample clocks plus ten decisions plus a write-back: 16 converter clocks
  localparam int unsigned SAMPLE_CLKS = 5;
  localparam logic [4:0] CONV_CLKS = 5'h10;
  localparam logic [7:0] DIV_RESET = 8'h00;
endpackage

// >>> tb/analog_front_model.sv
// Behavioural analog multiplexer and comparator facing the sequencer
`default_nettype none
module analog_front_model (
  // Clock
  input wire logic ref_clk,
  // Mux and converter control
  input wire logic [4:0] mux_select,
  input wire logic analog_power_on,
  input wire logic [9:0] trial_code,
  // Level on the external channel, as a code
  input wire logic [9:0] ext_level,
  // Comparator answer
  output logic cmp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] vin;
  logic noise_r = 1'b0;
  // Reference channels sit at the rails, others follow the pin
  always_comb begin
    case (mux_select)
      5'h1d: vin = 10'h3ff;
      5'h1e: vin = 10'h000;
      default: vin = ext_level;
    endcase
  end
  // A powered-off comparator must not look like a steady answer
  always_ff @(posedge ref_clk) begin
    noise_r <= ~noise_r;
  end
  // Input taken half a step above its code, so every code is reachable
  assign cmp_high = analog_power_on ? (vin >= trial_code) : noise_r;
endmodule
`default_nettype wire

// >>> tb/tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer
`default_nettype none
module tb_sar_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0, cont = 1'b0, ie = 1'b0, hi_rd = 1'b0, lo_rd = 1'b0, stop = 1'b0, f0 = 1'b0, f1 = 1'b0;
  logic [4:0] ch = 5'h1f;
  logic [7:0] div = 8'h03; // Scaled converter clock, one tick per 4 cycles
  logic [7:0] pdata = 8'h5a, pdir = 8'hff, pins_in, pins_out, pins_oe, prd, rh, rl;
  logic [4:0] mux;
  logic pwr, cmp, flag, irq, sie, scont, busy;
  logic [9:0] trial, ext = 10'h000;
  logic [15:0] e;
  int n_errors = 0, num_checks = 0, cyc = 0, n;
  // Pins not driven by the port float up through pull-ups
  assign pins_in = (pins_oe & pins_out) | ~pins_oe;
  sar_adc_sequencer u_dut (.ref_clk(ref_clk), .rst(rst), .conv_status_ctrl_reg_wr(wr), .channel_select_field(ch),
    .continuous_conv_bit(cont), .conv_irq_enable(ie), .conv_clock_divider(div), .result_format_bit0(f0),
    .result_format_bit1(f1), .result_high_rd(hi_rd), .result_low_rd(lo_rd), .stop_mode(stop), .port_data(pdata),
    .port_dir(pdir), .shared_port_pins_in(pins_in), .shared_port_pins_out(pins_out), .shared_port_pins_oe(pins_oe),
    .port_read_data(prd), .mux_select(mux), .analog_power_on(pwr), .trial_code(trial), .cmp_high(cmp),
    .result_high_reg(rh), .result_low_reg(rl), .conv_done_flag(flag), .conv_irq(irq), .conv_status_irq_en(sie),
    .conv_status_cont(scont), .conv_busy(busy));
  analog_front_model u_afe (.ref_clk(ref_clk), .mux_select(mux), .analog_power_on(pwr), .trial_code(trial),
    .ext_level(ext), .cmp_high(cmp));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // A hang is cut short well beyond the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Inputs always move 2 ns after a rising edge
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask
  // A quiet edge after each strobe keeps back-to-back calls from merging into one
  task automatic pulse(input logic h, input logic l);
    hi_rd = h;
    lo_rd = l;
    step(1);
    hi_rd = 1'b0;
    lo_rd = 1'b0;
    step(1);
  endtask
  task automatic start(input logic [4:0] c, input logic co, input logic ien);
    ch = c;
    cont = co;
    ie = ien;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  // Bounded wait for the sequencer to go idle; n counts cycles from the write
  task automatic conv(input logic [4:0] c, input logic co, input logic ien);
    start(c, co, ien);
    n = 2;
    step(1);
    while (busy !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    chk1(n < 200, 1'b1);
    step(2);
  endtask
  function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] v);
    case (f)
      2'h0: return {v[9:2], v[1:0], 6'h00};
      2'h1: return {6'h00, v[9:8], v[7:0]};
      2'h2: return {~v[9], v[8:2], v[1:0], 6'h00};
      default: return {8'h00, v[9:2]};
    endcase
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(8);
    rst = 1'b0;
    chk1(flag, 1'b0);
    chk1(irq, 1'b0);
    chk1(scont | sie | busy, 1'b0);
    chk1(pwr, 1'b0);
    // Every result format, with the port driving the other pins
    for (int f = 0; f < 4; f++) begin
      {f1, f0} = f[1:0];
      ext = 10'h2a5 ^ f[9:0];
      start(5'h03, 1'b0, 1'b0);
      chk8({3'h0, mux}, 8'h03);
      chk8(pins_oe, 8'hf7);
      chk8(pins_out & 8'hf7, 8'h52);
      conv(5'h03, 1'b0, 1'b0);
      chk1(n >= 16 * (div + 1) && n <= 17 * (div + 1), 1'b1);
      chk8(prd, 8'h52);
      chk1(flag, 1'b1);
      e = fmt_exp(f[1:0], ext);
      chk8(rh, e[15:8]);
      chk8(rl, e[7:0]);
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      chk1(flag, 1'b0);
    end
    // Reference channels give the end codes
    {f1, f0} = 2'h1;
    conv(5'h1d, 1'b0, 1'b0);
    chk8(rl, 8'hff);
    conv(5'h1e, 1'b0, 1'b0);
    chk8(rl, 8'h00);
    // High read without low read holds off new results
    {f1, f0} = 2'h0;
    ext = 10'h155;
    conv(5'h00, 1'b0, 1'b0);
    pulse(1'b1, 1'b0);
    ext = 10'h0ff;
    conv(5'h00, 1'b0, 1'b0);
    chk8(rh, 8'h55);
    chk8(rl, 8'h40);
    pulse(1'b0, 1'b1);
    conv(5'h00, 1'b0, 1'b0);
    chk8(rh, 8'h3f);
    chk8(rl, 8'hc0);
    // Truncated format ignores the interlock
    {f1, f0} = 2'h3;
    pulse(1'b1, 1'b0);
    ext = 10'h3c3;
    conv(5'h00, 1'b0, 1'b0);
    chk8(rl, 8'hf0);
    chk8(rh, 8'h00);
    // Interrupt mode, cleared by a read and by a control write
    {f1, f0} = 2'h1;
    conv(5'h02, 1'b0, 1'b1);
    chk1(irq, 1'b1);
    chk1(flag, 1'b0);
    pulse(1'b0, 1'b1);
    chk1(irq, 1'b0);
    conv(5'h02, 1'b0, 1'b1);
    start(5'h02, 1'b0, 1'b0);
    chk1(irq, 1'b0);
    step(100);
    // Continuous mode overwrites unread results
    ext = 10'h100;
    start(5'h00, 1'b1, 1'b0);
    step(80);
    chk1(scont, 1'b1);
    chk8(rh, 8'h01);
    ext = 10'h200;
    step(160);
    chk8(rh, 8'h02);
    start(5'h00, 1'b0, 1'b0);
    step(100);
    pulse(1'b0, 1'b1);
    step(100);
    chk1(flag, 1'b0);
    chk1(busy, 1'b0);
    // Stop mode aborts a conversion in flight
    start(5'h00, 1'b0, 1'b0);
    step(10);
    stop = 1'b1;
    step(100);
    chk1(flag, 1'b0);
    chk1(busy, 1'b0);
    stop = 1'b0;
    step(80);
    // Continuous mode picks up again once stop is lifted
    start(5'h00, 1'b1, 1'b0);
    stop = 1'b1;
    step(20);
    chk1(busy, 1'b0);
    stop = 1'b0;
    step(10);
    chk1(busy, 1'b1);
    start(5'h00, 1'b0, 1'b0);
    // All-ones channel powers the converter off
    pulse(1'b0, 1'b1);
    start(5'h1f, 1'b0, 1'b0);
    step(100);
    chk1(pwr, 1'b0);
    chk1(flag, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
